//--- core/at2_pkg.sv
package at2_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h37;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h70;
  localparam logic [7:0] IDX_CTL_A = 8'hb0;
  localparam logic [7:0] IDX_CTL_B = 8'hb1;
  localparam logic [7:0] IDX_COUNT = 8'hb2;
  localparam logic [7:0] IDX_CMP_A = 8'hb3;
  localparam logic [7:0] IDX_CMP_B = 8'hb4;
  localparam logic [7:0] IDX_ASYNC = 8'hb6;
  localparam logic [7:0] IDX_CPU_FLAGS = 8'hc0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTLB_FORCE_A = 7;
  localparam int CTLB_FORCE_B = 6;
  localparam int CTLB_WAVE_HI = 3;
  localparam int ASYNC_EXT_EN = 6;
  localparam int ASYNC_SEL = 5;
  localparam int BUSY_COUNT = 4;
  localparam int BUSY_CMP_A = 3;
  localparam int BUSY_CMP_B = 2;
  localparam int BUSY_CTL_A = 1;
  localparam int BUSY_CTL_B = 0;
  localparam int FLAG_MATCH_B = 2;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_OVF = 0;
  localparam int CPU_GIE = 7;

  // ----------------------------------------------------------------
  // Masks, values after reset and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CTLA_MASK = 8'hf3;
  localparam logic [7:0] CTLB_MASK = 8'h0f;
  localparam logic [7:0] FLAG_MASK = 8'h07;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_BUSY = 5'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // ----------------------------------------------------------------
  // Prescaler taps
  // ----------------------------------------------------------------
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_DIV1 = 10'h000;
  localparam logic [9:0] PRE_DIV8 = 10'h007;
  localparam logic [9:0] PRE_DIV32 = 10'h01f;
  localparam logic [9:0] PRE_DIV64 = 10'h03f;
  localparam logic [9:0] PRE_DIV128 = 10'h07f;
  localparam logic [9:0] PRE_DIV256 = 10'h0ff;
  localparam logic [9:0] PRE_DIV1024 = 10'h3ff;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } at2_dir_e;

  typedef struct packed {
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
  } at2_cfg_s;

endpackage

//--- core/at2_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module at2_prescale
  import at2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic [2:0] clk_sel,
  output logic cnt_tick
);

  logic [PRE_W-1:0] pre_r;

  function automatic logic [PRE_W-1:0] tap_mask(input logic [2:0] sel);
    case (sel)
      3'h2: tap_mask = PRE_DIV8;
      3'h3: tap_mask = PRE_DIV32;
      3'h4: tap_mask = PRE_DIV64;
      3'h5: tap_mask = PRE_DIV128;
      3'h6: tap_mask = PRE_DIV256;
      3'h7: tap_mask = PRE_DIV1024;
      default: tap_mask = PRE_DIV1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Free-running prefix counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (src_tick) begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Code zero stops the counter; other codes pick a tap.
  always_comb begin
    cnt_tick = src_tick && (clk_sel != 3'h0) &&
               ((pre_r & tap_mask(clk_sel)) == tap_mask(clk_sel));
  end

endmodule
`default_nettype wire

//--- core/at2_wave.sv
`timescale 1ns/1ps
`default_nettype none
module at2_wave
  import at2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic match,
  input wire logic force_pulse,
  input wire logic bottom,
  input wire logic count_down,
  input wire logic [1:0] out_mode,
  input wire logic [2:0] wave_mode,
  input wire logic toggle_ok,
  output logic wave_out,
  output logic wave_oe
);

  logic pwm;
  logic fast;
  logic tog_pwm;

  assign pwm = wave_mode[0];
  assign fast = wave_mode[1];
  assign tog_pwm = toggle_ok && wave_mode[2];
  // In PWM the toggle code disconnects the pin unless toggling is allowed.
  assign wave_oe = (out_mode != 2'b00) && !(pwm && out_mode == 2'b01 && !tog_pwm);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out <= 1'b0;
    end else if (!pwm) begin
      if (match || force_pulse) begin
        case (out_mode)
          2'b01: wave_out <= !wave_out;
          2'b10: wave_out <= 1'b0;
          2'b11: wave_out <= 1'b1;
          default: wave_out <= wave_out;
        endcase
      end
    end else if (match) begin
      case (out_mode)
        2'b01: wave_out <= tog_pwm ? !wave_out : wave_out;
        2'b10: wave_out <= !fast && count_down;
        2'b11: wave_out <= fast || !count_down;
        default: wave_out <= wave_out;
      endcase
    end else if (fast && bottom && out_mode[1]) begin
      wave_out <= !out_mode[0];
    end
  end

endmodule
`default_nettype wire

//--- core/at2_top.sv
`timescale 1ns/1ps
`default_nettype none
module at2_top
  import at2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_osc_in,
  input wire logic [2:0] int_taken,
  output logic [2:0] irq_req,
  output logic wave_out_a,
  output logic wave_oe_a,
  output logic wave_out_b,
  output logic wave_oe_b,
  output logic xtal_osc_run,
  output logic ext_buf_en
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  at2_cfg_s hold_r, cfg_r;
  at2_dir_e dir_r;
  logic [7:0] cnt_hold_r, count_r, flags_r, mask_r, async_r;
  logic [7:0] idx, top, busy_view, rd_mux;
  logic [4:0] pend_r, xfer;
  logic [2:0] irq_r, wave_mode;
  logic [1:0] force_pend_r, force_pulse_r;
  logic [31:0] prdata_r;
  logic gie_r, blk_r, osc_s1_r, osc_s2_r, osc_s3_r;
  logic addr_ok, wr_en, rd_setup, src_tick, cnt_tick, pwm, phase;
  logic at_top, at_bottom, match_a, match_b, ovf_evt, fast_bottom;

  function automatic logic known_idx(input logic [7:0] i);
    case (i)
      IDX_IRQ_FLAGS, IDX_IRQ_MASK, IDX_CTL_A, IDX_CTL_B,
      IDX_COUNT, IDX_CMP_A, IDX_CMP_B, IDX_ASYNC, IDX_CPU_FLAGS: known_idx = 1'b1;
      default: known_idx = 1'b0;
    endcase
  endfunction
  function automatic logic wr_hit(input logic en, input logic [7:0] i, input logic [7:0] want);
    wr_hit = en && (i == want);
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && known_idx(idx);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  // The oscillator pin is slow against pclk, so its rising edge becomes
  // a one-cycle enable; pclk must run at least four times faster.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {osc_s3_r, osc_s2_r, osc_s1_r} <= 3'b000;
    end else begin
      {osc_s3_r, osc_s2_r, osc_s1_r} <= {osc_s2_r, osc_s1_r, timer_osc_in};
    end
  end

  assign src_tick = async_r[ASYNC_SEL] ? (osc_s2_r && !osc_s3_r) : 1'b1;
  assign xtal_osc_run = async_r[ASYNC_SEL] && !async_r[ASYNC_EXT_EN];
  assign ext_buf_en = async_r[ASYNC_SEL] && async_r[ASYNC_EXT_EN];
  at2_prescale u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .clk_sel(cfg_r.ctl_b[2:0]),
    .cnt_tick(cnt_tick)
  );

  // ----------------------------------------------------------------
  // Holding registers and busy handshake
  // ----------------------------------------------------------------
  // A pending value moves across on the next source tick, which in
  // synchronous mode is the very next cycle.
  assign xfer = pend_r & {5{src_tick}};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= '0;
      cnt_hold_r <= RST_BYTE;
    end else begin
      if (wr_hit(wr_en, idx, IDX_CTL_A)) begin
        hold_r.ctl_a <= pwdata[7:0] & CTLA_MASK;
      end
      if (wr_hit(wr_en, idx, IDX_CTL_B)) begin
        hold_r.ctl_b <= pwdata[7:0] & CTLB_MASK;
      end
      if (wr_hit(wr_en, idx, IDX_CMP_A)) begin
        hold_r.cmp_a <= pwdata[7:0];
      end
      if (wr_hit(wr_en, idx, IDX_CMP_B)) begin
        hold_r.cmp_b <= pwdata[7:0];
      end
      if (wr_hit(wr_en, idx, IDX_COUNT)) begin
        cnt_hold_r <= pwdata[7:0];
      end
    end
  end

  // A write arriving in the transfer cycle keeps its busy bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= RST_BUSY;
    end else begin
      pend_r[BUSY_COUNT] <= wr_hit(wr_en, idx, IDX_COUNT) || (pend_r[BUSY_COUNT] && !xfer[BUSY_COUNT]);
      pend_r[BUSY_CMP_A] <= wr_hit(wr_en, idx, IDX_CMP_A) || (pend_r[BUSY_CMP_A] && !xfer[BUSY_CMP_A]);
      pend_r[BUSY_CMP_B] <= wr_hit(wr_en, idx, IDX_CMP_B) || (pend_r[BUSY_CMP_B] && !xfer[BUSY_CMP_B]);
      pend_r[BUSY_CTL_A] <= wr_hit(wr_en, idx, IDX_CTL_A) || (pend_r[BUSY_CTL_A] && !xfer[BUSY_CTL_A]);
      pend_r[BUSY_CTL_B] <= wr_hit(wr_en, idx, IDX_CTL_B) || (pend_r[BUSY_CTL_B] && !xfer[BUSY_CTL_B]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '0;
    end else begin
      if (xfer[BUSY_CTL_A]) begin
        cfg_r.ctl_a <= hold_r.ctl_a;
      end
      if (xfer[BUSY_CTL_B]) begin
        cfg_r.ctl_b <= hold_r.ctl_b;
      end
      if (xfer[BUSY_CMP_A]) begin
        cfg_r.cmp_a <= hold_r.cmp_a;
      end
      if (xfer[BUSY_CMP_B]) begin
        cfg_r.cmp_b <= hold_r.cmp_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // Force strobes
  // ----------------------------------------------------------------
  // The strobe travels with the control B transfer so that it lands in
  // the same domain step as the new control value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_pend_r <= 2'b00;
      force_pulse_r <= 2'b00;
    end else begin
      force_pulse_r <= 2'b00;
      if (wr_hit(wr_en, idx, IDX_CTL_B)) begin
        force_pend_r <= {pwdata[CTLB_FORCE_A], pwdata[CTLB_FORCE_B]};
      end else if (xfer[BUSY_CTL_B]) begin
        force_pend_r <= 2'b00;
        force_pulse_r <= force_pend_r & {2{!hold_r.ctl_b[CTLB_WAVE_HI] && !pwm}};
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter unit
  // ----------------------------------------------------------------
  assign wave_mode = {cfg_r.ctl_b[CTLB_WAVE_HI], cfg_r.ctl_a[1:0]};
  assign pwm = wave_mode[0];
  assign phase = wave_mode[0] && !wave_mode[1];
  assign top = (wave_mode[2] || wave_mode == 3'h2) ? cfg_r.cmp_a : COUNT_MAX;
  assign at_top = (count_r == top);
  assign at_bottom = (count_r == COUNT_BOTTOM);
  assign fast_bottom = cnt_tick && !phase && at_top;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= RST_BYTE;
      dir_r <= DIR_UP;
    end else if (xfer[BUSY_COUNT]) begin
      count_r <= cnt_hold_r;
    end else if (cnt_tick) begin
      if (!phase) begin
        count_r <= at_top ? COUNT_BOTTOM : count_r + 8'h01;
        dir_r <= DIR_UP;
      end else begin
        case (dir_r)
          DIR_UP: begin
            if (at_top) begin
              count_r <= count_r - 8'h01;
              dir_r <= DIR_DOWN;
            end else begin
              count_r <= count_r + 8'h01;
            end
          end
          DIR_DOWN: begin
            if (at_bottom) begin
              count_r <= count_r + 8'h01;
              dir_r <= DIR_UP;
            end else begin
              count_r <= count_r - 8'h01;
            end
          end
          default: dir_r <= DIR_UP;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_r <= 1'b0;
    end else if (xfer[BUSY_COUNT]) begin
      blk_r <= 1'b1;
    end else if (cnt_tick) begin
      blk_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Compare and overflow events
  // ----------------------------------------------------------------
  assign match_a = cnt_tick && !blk_r && (count_r == cfg_r.cmp_a);
  assign match_b = cnt_tick && !blk_r && (count_r == cfg_r.cmp_b);
  assign ovf_evt = cnt_tick && (phase ? (dir_r == DIR_DOWN && at_bottom)
                   : (wave_mode[2] ? at_top : count_r == COUNT_MAX));

  // Set wins over a clear in the same cycle, so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= RST_BYTE;
    end else begin
      flags_r[FLAG_MATCH_A] <= match_a || (flags_r[FLAG_MATCH_A] && !int_taken[FLAG_MATCH_A]
        && !(wr_hit(wr_en, idx, IDX_IRQ_FLAGS) && pwdata[FLAG_MATCH_A]));
      flags_r[FLAG_MATCH_B] <= match_b || (flags_r[FLAG_MATCH_B] && !int_taken[FLAG_MATCH_B]
        && !(wr_hit(wr_en, idx, IDX_IRQ_FLAGS) && pwdata[FLAG_MATCH_B]));
      flags_r[FLAG_OVF] <= ovf_evt || (flags_r[FLAG_OVF] && !int_taken[FLAG_OVF]
        && !(wr_hit(wr_en, idx, IDX_IRQ_FLAGS) && pwdata[FLAG_OVF]));
    end
  end

  // ----------------------------------------------------------------
  // Mask, global enable, async status
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= RST_BYTE;
      gie_r <= 1'b0;
      async_r <= RST_BYTE;
    end else begin
      if (wr_hit(wr_en, idx, IDX_IRQ_MASK)) begin
        mask_r <= pwdata[7:0] & FLAG_MASK;
      end
      if (wr_hit(wr_en, idx, IDX_CPU_FLAGS)) begin
        gie_r <= pwdata[CPU_GIE];
      end
      if (wr_hit(wr_en, idx, IDX_ASYNC)) begin
        async_r[ASYNC_EXT_EN] <= pwdata[ASYNC_EXT_EN];
        async_r[ASYNC_SEL] <= pwdata[ASYNC_SEL];
      end
    end
  end

  // Flags are taken from flip-flops only, never from raw events.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 3'b000;
    end else begin
      irq_r <= flags_r[2:0] & mask_r[2:0] & {3{gie_r}};
    end
  end
  assign irq_req = irq_r;
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign busy_view = {3'b000, pend_r & {5{async_r[ASYNC_SEL]}}};
  always_comb begin
    case (idx)
      IDX_IRQ_FLAGS: rd_mux = flags_r & FLAG_MASK;
      IDX_IRQ_MASK: rd_mux = mask_r;
      IDX_CTL_A: rd_mux = hold_r.ctl_a;
      IDX_CTL_B: rd_mux = hold_r.ctl_b & CTLB_MASK;
      IDX_COUNT: rd_mux = count_r;
      IDX_CMP_A: rd_mux = hold_r.cmp_a;
      IDX_CMP_B: rd_mux = hold_r.cmp_b;
      IDX_ASYNC: rd_mux = (async_r & 8'h60) | busy_view;
      IDX_CPU_FLAGS: rd_mux = {gie_r, 7'h00};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle and held through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= {24'h00_0000, addr_ok ? rd_mux : 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // Waveform outputs
  // ----------------------------------------------------------------
  // Forced pulses reach only the wave units: no flag, no counter clear.
  at2_wave u_wave_a (
    .pclk(pclk),
    .presetn(presetn),
    .match(match_a),
    .force_pulse(force_pulse_r[1]),
    .bottom(fast_bottom),
    .count_down(dir_r == DIR_DOWN),
    .out_mode(cfg_r.ctl_a[7:6]),
    .wave_mode(wave_mode),
    .toggle_ok(1'b1),
    .wave_out(wave_out_a),
    .wave_oe(wave_oe_a)
  );

  at2_wave u_wave_b (
    .pclk(pclk),
    .presetn(presetn),
    .match(match_b),
    .force_pulse(force_pulse_r[0]),
    .bottom(fast_bottom),
    .count_down(dir_r == DIR_DOWN),
    .out_mode(cfg_r.ctl_a[5:4]),
    .wave_mode(wave_mode),
    .toggle_ok(1'b0),
    .wave_out(wave_out_b),
    .wave_oe(wave_oe_b)
  );

endmodule
`default_nettype wire

//--- verif/at2_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module at2_top_asserts
  import at2_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_osc_in,
  input wire logic [2:0] int_taken,
  input wire logic [2:0] irq_req,
  input wire logic wave_out_a,
  input wire logic wave_oe_a,
  input wire logic wave_out_b,
  input wire logic wave_oe_b,
  input wire logic xtal_osc_run,
  input wire logic ext_buf_en
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Refused reads carry no register content, so only clean reads are judged.
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite && !pslverr;
  read_upper_a: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  force_read_a: assert property (rd_acc && paddr == 12'h2c4 |-> prdata[7:6] == 2'b00)
    else $error("force bits read back");
  ctlb_resv_a: assert property (rd_acc && paddr == 12'h2c4 |-> prdata[5:4] == 2'b00)
    else $error("control b reserved bits set");
  mask_resv_a: assert property (rd_acc && paddr == 12'h1c0 |-> prdata[7:3] == 5'h00)
    else $error("mask reserved bits set");
  flag_resv_a: assert property (rd_acc && paddr == 12'h0dc |-> prdata[7:3] == 5'h00)
    else $error("flag reserved bits set");
  stat_resv_a: assert property (rd_acc && paddr == 12'h2d8 |-> !prdata[7])
    else $error("status reserved bit set");
  busy_sync_a: assert property (rd_acc && paddr == 12'h2d8 && !xtal_osc_run && !ext_buf_en |-> prdata[4:0] == 5'h00)
    else $error("busy bit set in sync mode");
  osc_excl_a: assert property (!(xtal_osc_run && ext_buf_en))
    else $error("crystal and buffer both on");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved without setup");
  cover property (rd_acc && paddr == 12'h2d8 && prdata[4]);
  cover property (irq_req != 3'b000);
  cover property (pslverr);
endmodule
bind at2_top at2_top_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_osc_in(timer_osc_in), .int_taken(int_taken), .irq_req(irq_req), .wave_out_a(wave_out_a),
  .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b), .xtal_osc_run(xtal_osc_run),
  .ext_buf_en(ext_buf_en));
`default_nettype wire

//--- verif/at2_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module at2_top_bench
  import at2_pkg::*;
();
  // ----------------------------------------
  // Stimulus and wiring
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer_osc_in = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] int_taken = 3'h0;
  logic [31:0] prdata, v;
  logic pready, pslverr, e, w0, wave_out_a, wave_oe_a, wave_out_b, wave_oe_b, xtal_osc_run, ext_buf_en;
  logic [2:0] irq_req;
  int bad_count = 0;
  int compares = 0;
  localparam int DIV[7] = '{1, 8, 32, 64, 128, 256, 1024};
  at2_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_osc_in(timer_osc_in), .int_taken(int_taken), .irq_req(irq_req), .wave_out_a(wave_out_a),
    .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b), .xtal_osc_run(xtal_osc_run),
    .ext_buf_en(ext_buf_en));
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // The answer is waited for, never assumed, so a slower slave still passes.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] rv,
                     output logic er);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, v, e);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, v, e);
    `CHK(v, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_regs;
    rd_chk(IDX_IRQ_FLAGS, 32'h0);
    rd_chk(IDX_IRQ_MASK, 32'h0);
    rd_chk(IDX_CTL_B, 32'h0);
    rd_chk(IDX_ASYNC, 32'h0);
    wr(IDX_IRQ_MASK, 8'hff);
    rd_chk(IDX_IRQ_MASK, 32'h07);
    wr(IDX_CTL_B, 8'h37);
    rd_chk(IDX_CTL_B, 32'h07);
    wr(IDX_CTL_B, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    apb(1'b0, 8'h01, 8'h00, v, e);
    `CHK(e, 1'b1);
    `CHK(v, 32'h0);
  endtask
  task automatic t_prescale;
    wr(IDX_COUNT, 8'ha5);
    idle(2);
    rd_chk(IDX_COUNT, 32'ha5);
    for (int c = 1; c < 8; c++) begin
      wr(IDX_COUNT, 8'h00);
      idle(2);
      wr(IDX_CTL_B, 8'(c));
      idle(8 * DIV[c - 1]);
      wr(IDX_CTL_B, 8'h00);
      apb(1'b0, IDX_COUNT, 8'h00, v, e);
      `CHK(v >= 32'((8 * DIV[c - 1] + 3) / DIV[c - 1]) && v <= 32'((9 * DIV[c - 1] + 2) / DIV[c - 1]), 1'b1);
      idle(20);
      rd_chk(IDX_COUNT, v);
    end
  endtask
  task automatic t_flags;
    wr(IDX_CMP_A, 8'h20);
    wr(IDX_CMP_B, 8'h30);
    wr(IDX_COUNT, 8'h1c);
    idle(2);
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_CTL_B, 8'h01);
    idle(40);
    wr(IDX_CTL_B, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 32'h06);
    wr(IDX_IRQ_FLAGS, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 32'h06);
    wr(IDX_IRQ_MASK, 8'h04);
    idle(2);
    `CHK(irq_req, 3'b000);
    wr(IDX_CPU_FLAGS, 8'h80);
    idle(2);
    `CHK(irq_req, 3'b100);
    int_taken <= 3'b100;
    @(posedge pclk);
    int_taken <= 3'b000;
    idle(3);
    `CHK(irq_req, 3'b000);
    rd_chk(IDX_IRQ_FLAGS, 32'h02);
    wr(IDX_IRQ_FLAGS, 8'h02);
    rd_chk(IDX_IRQ_FLAGS, 32'h00);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_COUNT, 8'hfc);
    idle(2);
    wr(IDX_CTL_B, 8'h01);
    idle(10);
    wr(IDX_CTL_B, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 32'h01);
    `CHK(irq_req, 3'b001);
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_CMP_A, 8'h50);
    wr(IDX_COUNT, 8'h50);
    idle(2);
    wr(IDX_CTL_B, 8'h01);
    idle(4);
    wr(IDX_CTL_B, 8'h00);
    rd_chk(IDX_IRQ_FLAGS, 32'h00);
  endtask
  task automatic t_force;
    wr(IDX_CTL_A, 8'h40);
    idle(4);
    w0 = wave_out_a;
    wr(IDX_CTL_B, 8'h80);
    idle(5);
    `CHK(wave_oe_a, 1'b1);
    `CHK(wave_out_a, !w0);
    `CHK(wave_oe_b, 1'b0);
    `CHK(wave_out_b, 1'b0);
    rd_chk(IDX_CTL_B, 32'h00);
    rd_chk(IDX_IRQ_FLAGS, 32'h00);
    wr(IDX_CTL_A, 8'h41);
    idle(4);
    w0 = wave_out_a;
    wr(IDX_CTL_B, 8'h80);
    idle(5);
    `CHK(wave_out_a, w0);
    wr(IDX_CTL_B, 8'h00);
    wr(IDX_CTL_A, 8'h00);
  endtask
  task automatic t_async;
    wr(IDX_ASYNC, 8'h20);
    `CHK({xtal_osc_run, ext_buf_en}, 2'b10);
    wr(IDX_COUNT, 8'h33);
    wr(IDX_CMP_B, 8'h44);
    rd_chk(IDX_ASYNC, 32'h34);
    rd_chk(IDX_CMP_B, 32'h44);
    timer_osc_in <= 1'b1;
    idle(6);
    timer_osc_in <= 1'b0;
    idle(6);
    rd_chk(IDX_ASYNC, 32'h20);
    rd_chk(IDX_COUNT, 32'h33);
    wr(IDX_ASYNC, 8'h00);
    wr(IDX_ASYNC, 8'h40);
    wr(IDX_ASYNC, 8'h60);
    `CHK({xtal_osc_run, ext_buf_en}, 2'b01);
    wr(IDX_ASYNC, 8'h00);
  endtask
  initial begin
    #3000000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_regs();
    t_prescale();
    t_flags();
    t_force();
    t_async();
    finish_test();
  end
endmodule
`default_nettype wire
